// File: pxio_pkg.sv
`default_nettype none
package pxio_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_PINS = 32;
  localparam int NUM_SIGS = 33;
  localparam int SIG_IDX_W = 6;
  localparam int PIN_IDX_W = 5;
  // signal priority order
  localparam int SIG_UART_A_TX = 0;
  localparam int SIG_UART_A_RX = 1;
  localparam int SIG_SPI_SCK = 2;
  localparam int SIG_SPI_NSS = 5;
  localparam int SIG_SDA = 6;
  localparam int SIG_SCL = 7;
  localparam int SIG_UART_B_TX = 8;
  localparam int SIG_UART_B_RX = 9;
  localparam int SIG_CEX0 = 10;
  localparam int SIG_NUM_CEX = 6;
  localparam int SIG_ECI = 16;
  localparam int SIG_CP0 = 17;
  localparam int SIG_CP1 = 18;
  localparam int SIG_CP2 = 19;
  localparam int SIG_T0 = 20;
  localparam int SIG_INT0 = 21;
  localparam int SIG_T1 = 22;
  localparam int SIG_INT1 = 23;
  localparam int SIG_T2 = 24;
  localparam int SIG_T2EX = 25;
  localparam int SIG_T3 = 26;
  localparam int SIG_T3EX = 27;
  localparam int SIG_T4 = 28;
  localparam int SIG_T4EX = 29;
  localparam int SIG_SYSCLK = 30;
  localparam int SIG_CONV_A = 31;
  localparam int SIG_CONV_B = 32;
  // enable bit positions
  localparam int B0_SMB = 0;
  localparam int B0_SPI = 1;
  localparam int B0_UART_A = 2;
  localparam int B0_PCA_LO = 3;
  localparam int B0_PCA_HI = 5;
  localparam int B0_ECI = 6;
  localparam int B0_CP0 = 7;
  localparam int B1_CP1 = 0;
  localparam int B1_T0 = 1;
  localparam int B1_INT0 = 2;
  localparam int B1_T1 = 3;
  localparam int B1_INT1 = 4;
  localparam int B1_T2 = 5;
  localparam int B1_T2EX = 6;
  localparam int B1_SYSCLK = 7;
  localparam int B2_CONV_A = 0;
  localparam int B2_T4EX = 1;
  localparam int B2_UART_B = 2;
  localparam int B2_T4 = 3;
  localparam int B2_GLOBAL_EN = 4;
  localparam int B2_PULLUP_OFF = 7;
  localparam int B3_T3 = 0;
  localparam int B3_T3EX = 1;
  localparam int B3_CONV_B = 2;
  localparam int B3_CP2 = 3;
  // pins never skipped in analog mode, first analog-capable pin
  localparam int NOSKIP_LO = 16;
  localparam int NOSKIP_HI = 17;
  localparam int ANALOG_FIRST_PIN = 8;
  // register map: group in adr[6:4], port in adr[3:2]
  localparam logic [2:0] GRP_ROUTE = 3'h0;
  localparam logic [2:0] GRP_PORT = 3'h1;
  localparam logic [2:0] GRP_LATCH = 3'h2;
  localparam logic [2:0] GRP_DRIVE = 3'h3;
  localparam logic [2:0] GRP_INMODE = 3'h4;
  localparam logic [2:0] GRP_SET = 3'h5;
  localparam logic [2:0] GRP_CLR = 3'h6;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_INMODE = 8'hFF;
endpackage
`default_nettype wire

// File: pxio_crossbar.sv
`timescale 1ns/1ps
`default_nettype none
module pxio_crossbar #(
  parameter int ADR_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // peripheral side, one bit per signal in priority order
  input wire logic [pxio_pkg::NUM_SIGS-1:0] periphOut,
  input wire logic [pxio_pkg::NUM_SIGS-1:0] periphDriveEn,
  input wire logic uartAMode0,
  input wire logic uartBMode0,
  output logic [pxio_pkg::NUM_SIGS-1:0] periphIn,
  // pins, port n bit b at index 8*n+b
  input wire logic [pxio_pkg::NUM_PINS-1:0] pinIn,
  output logic [pxio_pkg::NUM_PINS-1:0] pinOut,
  output logic [pxio_pkg::NUM_PINS-1:0] pinOeN,
  output logic [pxio_pkg::NUM_PINS-1:0] pullupEn
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] routeCfg_r [pxio_pkg::NUM_PORTS];
  logic [7:0] latch_r [pxio_pkg::NUM_PORTS];
  logic [7:0] driveMode_r [pxio_pkg::NUM_PORTS];
  logic [7:0] inputMode_r [pxio_pkg::NUM_PORTS];
  logic [pxio_pkg::NUM_PINS-1:0] pinSample_r;
  logic ack_r;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic busHit;
  logic wrHit;
  logic [2:0] grp;
  logic [1:0] portSel;
  logic [7:0] wrByte;

  ////////////////////////////////////////////////////////////////////////////
  // flattened views
  logic [pxio_pkg::NUM_PINS-1:0] latchFlat;
  logic [pxio_pkg::NUM_PINS-1:0] driveFlat;
  logic [pxio_pkg::NUM_PINS-1:0] analogPin;
  logic [pxio_pkg::NUM_PINS-1:0] skipPin;
  logic [pxio_pkg::NUM_PINS-1:0] digitalIn;
  logic [pxio_pkg::NUM_SIGS-1:0] sigEn;
  logic globalEn;
  logic pullupOff;

  ////////////////////////////////////////////////////////////////////////////
  // allocation results
  logic [pxio_pkg::NUM_SIGS-1:0] sigHit;
  logic [pxio_pkg::PIN_IDX_W-1:0] sigPin [pxio_pkg::NUM_SIGS];
  logic [pxio_pkg::NUM_PINS-1:0] pinHit;
  logic [pxio_pkg::SIG_IDX_W-1:0] pinSig [pxio_pkg::NUM_PINS];

  ////////////////////////////////////////////////////////////////////////////
  // pin next values
  logic [pxio_pkg::NUM_PINS-1:0] pinOut_nxt;
  logic [pxio_pkg::NUM_PINS-1:0] pinOeN_nxt;
  logic [pxio_pkg::NUM_PINS-1:0] pullupEn_nxt;
  logic [pxio_pkg::NUM_SIGS-1:0] periphIn_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic sigIs(input logic [pxio_pkg::SIG_IDX_W-1:0] s, input int idx);
    sigIs = (s == pxio_pkg::SIG_IDX_W'(idx));
  endfunction

  function automatic logic [7:0] portByte(input logic [pxio_pkg::NUM_PINS-1:0] v,
                                          input logic [1:0] n);
    portByte = v[8*n +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign grp = wb_adr_i[6:4];
  assign portSel = wb_adr_i[3:2];
  assign wrByte = wb_dat_i[7:0];
  assign busHit = wb_cyc_i && wb_stb_i && !ack_r;
  assign wrHit = busHit && wb_we_i && wb_sel_i[0];
  assign globalEn = routeCfg_r[2][pxio_pkg::B2_GLOBAL_EN];
  assign pullupOff = routeCfg_r[2][pxio_pkg::B2_PULLUP_OFF];

  always_comb begin
    for (int n = 0; n < pxio_pkg::NUM_PORTS; n++) begin
      latchFlat[8*n +: 8] = latch_r[n];
      driveFlat[8*n +: 8] = driveMode_r[n];
      analogPin[8*n +: 8] = (n == 0) ? 8'h00 : ~inputMode_r[n];
    end
  end

  always_comb begin
    for (int p = 0; p < pxio_pkg::NUM_PINS; p++) begin
      skipPin[p] = analogPin[p] && p != pxio_pkg::NOSKIP_LO && p != pxio_pkg::NOSKIP_HI;
    end
  end

  assign digitalIn = pinSample_r & ~analogPin;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone handshake
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busHit;
    end
  end

  always_comb begin
    rdData_nxt = 32'h0000_0000;
    unique case (grp)
      pxio_pkg::GRP_ROUTE: rdData_nxt[7:0] = routeCfg_r[portSel];
      pxio_pkg::GRP_PORT: rdData_nxt[7:0] = portByte(digitalIn, portSel);
      pxio_pkg::GRP_LATCH: rdData_nxt[7:0] = latch_r[portSel];
      pxio_pkg::GRP_DRIVE: rdData_nxt[7:0] = driveMode_r[portSel];
      pxio_pkg::GRP_INMODE: rdData_nxt[7:0] = inputMode_r[portSel];
      default: rdData_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_r <= 32'h0000_0000;
    end else if (busHit && !wb_we_i) begin
      rdData_r <= rdData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration writes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < pxio_pkg::NUM_PORTS; n++) begin
        routeCfg_r[n] <= pxio_pkg::RST_ROUTE;
      end
    end else if (wrHit && grp == pxio_pkg::GRP_ROUTE) begin
      routeCfg_r[portSel] <= wrByte;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < pxio_pkg::NUM_PORTS; n++) begin
        driveMode_r[n] <= pxio_pkg::RST_DRIVE;
      end
    end else if (wrHit && grp == pxio_pkg::GRP_DRIVE) begin
      driveMode_r[portSel] <= wrByte;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < pxio_pkg::NUM_PORTS; n++) begin
        inputMode_r[n] <= pxio_pkg::RST_INMODE;
      end
    end else if (wrHit && grp == pxio_pkg::GRP_INMODE && portSel != 2'h0) begin
      inputMode_r[portSel] <= wrByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port data latches, byte and bit access
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < pxio_pkg::NUM_PORTS; n++) begin
        latch_r[n] <= pxio_pkg::RST_LATCH;
      end
    end else if (wrHit) begin
      if (grp == pxio_pkg::GRP_PORT || grp == pxio_pkg::GRP_LATCH) begin
        latch_r[portSel] <= wrByte;
      end else if (grp == pxio_pkg::GRP_SET) begin
        latch_r[portSel] <= latch_r[portSel] | wrByte;
      end else if (grp == pxio_pkg::GRP_CLR) begin
        latch_r[portSel] <= latch_r[portSel] & ~wrByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable expansion
  always_comb begin
    sigEn = '0;
    sigEn[pxio_pkg::SIG_UART_A_TX] = routeCfg_r[0][pxio_pkg::B0_UART_A];
    sigEn[pxio_pkg::SIG_UART_A_RX] = routeCfg_r[0][pxio_pkg::B0_UART_A];
    for (int s = pxio_pkg::SIG_SPI_SCK; s <= pxio_pkg::SIG_SPI_NSS; s++) begin
      sigEn[s] = routeCfg_r[0][pxio_pkg::B0_SPI];
    end
    sigEn[pxio_pkg::SIG_SDA] = routeCfg_r[0][pxio_pkg::B0_SMB];
    sigEn[pxio_pkg::SIG_SCL] = routeCfg_r[0][pxio_pkg::B0_SMB];
    sigEn[pxio_pkg::SIG_UART_B_TX] = routeCfg_r[2][pxio_pkg::B2_UART_B];
    sigEn[pxio_pkg::SIG_UART_B_RX] = routeCfg_r[2][pxio_pkg::B2_UART_B];
    for (int k = 0; k < pxio_pkg::SIG_NUM_CEX; k++) begin
      sigEn[pxio_pkg::SIG_CEX0 + k] =
        routeCfg_r[0][pxio_pkg::B0_PCA_HI:pxio_pkg::B0_PCA_LO] > 3'(k);
    end
    sigEn[pxio_pkg::SIG_ECI] = routeCfg_r[0][pxio_pkg::B0_ECI];
    sigEn[pxio_pkg::SIG_CP0] = routeCfg_r[0][pxio_pkg::B0_CP0];
    sigEn[pxio_pkg::SIG_CP1] = routeCfg_r[1][pxio_pkg::B1_CP1];
    sigEn[pxio_pkg::SIG_CP2] = routeCfg_r[3][pxio_pkg::B3_CP2];
    sigEn[pxio_pkg::SIG_T0] = routeCfg_r[1][pxio_pkg::B1_T0];
    sigEn[pxio_pkg::SIG_INT0] = routeCfg_r[1][pxio_pkg::B1_INT0];
    sigEn[pxio_pkg::SIG_T1] = routeCfg_r[1][pxio_pkg::B1_T1];
    sigEn[pxio_pkg::SIG_INT1] = routeCfg_r[1][pxio_pkg::B1_INT1];
    sigEn[pxio_pkg::SIG_T2] = routeCfg_r[1][pxio_pkg::B1_T2];
    sigEn[pxio_pkg::SIG_T2EX] = routeCfg_r[1][pxio_pkg::B1_T2EX];
    sigEn[pxio_pkg::SIG_T3] = routeCfg_r[3][pxio_pkg::B3_T3];
    sigEn[pxio_pkg::SIG_T3EX] = routeCfg_r[3][pxio_pkg::B3_T3EX];
    sigEn[pxio_pkg::SIG_T4] = routeCfg_r[2][pxio_pkg::B2_T4];
    sigEn[pxio_pkg::SIG_T4EX] = routeCfg_r[2][pxio_pkg::B2_T4EX];
    sigEn[pxio_pkg::SIG_SYSCLK] = routeCfg_r[1][pxio_pkg::B1_SYSCLK];
    sigEn[pxio_pkg::SIG_CONV_A] = routeCfg_r[2][pxio_pkg::B2_CONV_A];
    sigEn[pxio_pkg::SIG_CONV_B] = routeCfg_r[3][pxio_pkg::B3_CONV_B];
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority allocation walk
  always_comb begin
    int ptr;
    logic found;
    ptr = 0;
    found = 1'b0;
    sigHit = '0;
    pinHit = '0;
    for (int s = 0; s < pxio_pkg::NUM_SIGS; s++) begin
      sigPin[s] = '0;
    end
    for (int p = 0; p < pxio_pkg::NUM_PINS; p++) begin
      pinSig[p] = '0;
    end
    for (int s = 0; s < pxio_pkg::NUM_SIGS; s++) begin
      found = 1'b0;
      for (int p = 0; p < pxio_pkg::NUM_PINS; p++) begin
        if (sigEn[s] && !found && p >= ptr && !skipPin[p]) begin
          found = 1'b1;
          ptr = p + 1;
          sigHit[s] = 1'b1;
          sigPin[s] = pxio_pkg::PIN_IDX_W'(p);
          pinHit[p] = 1'b1;
          pinSig[p] = pxio_pkg::SIG_IDX_W'(s);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin driver logic
  always_comb begin
    logic val;
    logic drv;
    logic odForce;
    logic pushPull;
    logic lowDrive;
    val = 1'b1;
    drv = 1'b0;
    odForce = 1'b0;
    pushPull = 1'b0;
    lowDrive = 1'b0;
    for (int p = 0; p < pxio_pkg::NUM_PINS; p++) begin
      if (pinHit[p]) begin
        val = periphOut[pinSig[p]];
        drv = periphDriveEn[pinSig[p]];
        odForce = sigIs(pinSig[p], pxio_pkg::SIG_SDA) ||
                  sigIs(pinSig[p], pxio_pkg::SIG_SCL) ||
                  (sigIs(pinSig[p], pxio_pkg::SIG_UART_A_RX) && uartAMode0) ||
                  (sigIs(pinSig[p], pxio_pkg::SIG_UART_B_RX) && uartBMode0);
      end else begin
        val = latchFlat[p];
        drv = 1'b1;
        odForce = 1'b0;
      end
      drv = drv && globalEn;
      pushPull = driveFlat[p] && !odForce;
      lowDrive = drv && !val;
      pinOut_nxt[p] = val;
      pinOeN_nxt[p] = !(drv && (pushPull || !val));
      pullupEn_nxt[p] = !pullupOff && !analogPin[p] && !lowDrive;
    end
  end

  always_comb begin
    for (int s = 0; s < pxio_pkg::NUM_SIGS; s++) begin
      periphIn_nxt[s] = sigHit[s] && digitalIn[sigPin[s]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output and sample registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinSample_r <= '0;
    end else begin
      pinSample_r <= pinIn;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut <= '1;
      pinOeN <= '1;
      pullupEn <= '1;
      periphIn <= '0;
    end else begin
      pinOut <= pinOut_nxt;
      pinOeN <= pinOeN_nxt;
      pullupEn <= pullupEn_nxt;
      periphIn <= periphIn_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

endmodule
`default_nettype wire

// File: pxio_crossbar_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pxio_crossbar_checker #(
  parameter int ADR_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // peripherals
  input wire logic [pxio_pkg::NUM_SIGS-1:0] periphOut,
  input wire logic [pxio_pkg::NUM_SIGS-1:0] periphDriveEn,
  input wire logic uartAMode0,
  input wire logic uartBMode0,
  input wire logic [pxio_pkg::NUM_SIGS-1:0] periphIn,
  // pins
  input wire logic [pxio_pkg::NUM_PINS-1:0] pinIn,
  input wire logic [pxio_pkg::NUM_PINS-1:0] pinOut,
  input wire logic [pxio_pkg::NUM_PINS-1:0] pinOeN,
  input wire logic [pxio_pkg::NUM_PINS-1:0] pullupEn
);
  logic take;
  logic noRoute;
  logic [31:0] cfg_r;
  logic [31:0] drv_r;
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  assign noRoute = (cfg_r[15:0] == 16'h0) && (cfg_r[19:16] == 4'h0) && (cfg_r[27:24] == 4'h0);
  // shadow of routing config
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= 32'h0;
    end else if (take && wb_adr_i[6:4] == pxio_pkg::GRP_ROUTE) begin
      cfg_r[8*wb_adr_i[3:2] +: 8] <= wb_dat_i[7:0];
    end
  end
  // shadow of drive modes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      drv_r <= 32'h0;
    end else if (take && wb_adr_i[6:4] == pxio_pkg::GRP_DRIVE) begin
      drv_r[8*wb_adr_i[3:2] +: 8] <= wb_dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_lat; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat)
    else $error("ack missing after request");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_drivers_off; (!cfg_r[20] && !$past(cfg_r[20])) |-> (pinOeN == 32'hFFFFFFFF); endproperty
  a_drivers_off: assert property (p_drivers_off)
    else $error("pin driven while crossbar disabled");
  property p_pullup_off; (cfg_r[23] && $past(cfg_r[23])) |-> (pullupEn == 32'h0); endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pullup on while globally off");
  property p_no_fight; (~pinOeN & ~pinOut & pullupEn) == 32'h0; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("pullup on a pin driven low");
  property p_od_high; (drv_r == $past(drv_r)) |-> ((~pinOeN & pinOut & ~drv_r) == 32'h0); endproperty
  a_od_high: assert property (p_od_high)
    else $error("open-drain pin driven high");
  property p_no_route;
    (noRoute && $past(noRoute) && $past(noRoute, 2) && $past(noRoute, 3)) |-> (periphIn == '0);
  endproperty
  a_no_route: assert property (p_no_route)
    else $error("peripheral input seen with no routing");
  property p_uart_tx; (cfg_r[2] && $past(cfg_r[2])) |-> (pinOut[0] == $past(periphOut[0])); endproperty
  a_uart_tx: assert property (p_uart_tx)
    else $error("first pin not following uart tx");
  property p_rx_off;
    (cfg_r[2] && $past(cfg_r[2]) && !$past(periphDriveEn[1])) |-> pinOeN[1];
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("uart rx pin driven");
  property p_mode0_od;
    (cfg_r[2] && $past(cfg_r[2]) && $past(uartAMode0)) |-> (pinOeN[1] || !pinOut[1]);
  endproperty
  a_mode0_od: assert property (p_mode0_od)
    else $error("mode 0 rx pin driven high");
endmodule
bind pxio_crossbar pxio_crossbar_checker #(.ADR_W(ADR_W)) chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periphOut(periphOut),
  .periphDriveEn(periphDriveEn), .uartAMode0(uartAMode0), .uartBMode0(uartBMode0),
  .periphIn(periphIn), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .pullupEn(pullupEn)
);
`default_nettype wire

// File: pxio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pxio_pin_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // device pins
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOeN,
  input wire logic [31:0] pullupEn,
  // outside drivers
  input wire logic [31:0] extLvl,
  input wire logic [31:0] extEn,
  output logic [31:0] pinIn
);
  logic [31:0] float_r;
  // undriven unpulled pins wander
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      float_r <= 32'h0;
    end else begin
      float_r <= ~float_r;
    end
  end
  assign pinIn = (~pinOeN & pinOut) | (pinOeN & extEn & extLvl)
    | (pinOeN & ~extEn & (pullupEn | float_r));
endmodule
`default_nettype wire

// File: priority_crossbar_port_io_tb.sv
`timescale 1ns/1ps
`default_nettype none
module priority_crossbar_port_io_tb;
  logic clk_sys, sys_rst, wbCyc, wbStb, wbWe, wbAck, uartAMode0, uartBMode0;
  logic [7:0] wbAdr;
  logic [7:0] q;
  logic [31:0] wbDatI, wbDatO, pinIn, pinOut, pinOeN, pullupEn, extLvl, extEn;
  logic [pxio_pkg::NUM_SIGS-1:0] periphOut, periphDriveEn, periphIn;
  int errors;
  int num_checks;
  always #2.5 clk_sys = ~clk_sys;
  pxio_crossbar dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .periphOut(periphOut), .periphDriveEn(periphDriveEn), .uartAMode0(uartAMode0),
    .uartBMode0(uartBMode0), .periphIn(periphIn), .pinIn(pinIn), .pinOut(pinOut),
    .pinOeN(pinOeN), .pullupEn(pullupEn)
  );
  pxio_pin_model far_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pinOut(pinOut), .pinOeN(pinOeN),
    .pullupEn(pullupEn), .extLvl(extLvl), .extEn(extEn), .pinIn(pinIn)
  );
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wbx(input logic we, input logic [7:0] adr, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1) begin
      errors++;
      $display("ERROR %0t bus timeout", $time);
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    wbx(1'b1, adr, d);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    wbx(1'b0, adr, 8'h00);
    chk({24'h000000, q}, {24'h000000, exp});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    periphOut = '0;
    periphDriveEn = '0;
    uartAMode0 = 1'b0;
    uartBMode0 = 1'b0;
    extLvl = 32'h0;
    extEn = 32'h0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    chk(pinOeN, 32'hFFFFFFFF);
    chk(pullupEn, 32'hFFFFFFFF);
    rd(8'h30, 8'h00);
    rd(8'h44, 8'hFF);
    wr(8'h14, 8'h5A);
    wr(8'h34, 8'hFF);
    settle();
    chk(pinOeN, 32'hFFFFFFFF);
    $display("reset test done");
    wr(8'h08, 8'h10);
    wr(8'h18, 8'h0F);
    settle();
    chk(32'(pinOut[15:8]), 32'h5A);
    chk(32'(pinOeN[15:8]), 32'h00);
    chk(32'(pullupEn[15:8]), 32'h5A);
    chk(32'(pinOeN[23:16]), 32'h0F);
    chk(32'(pullupEn[23:16]), 32'h0F);
    wr(8'h54, 8'h01);
    wr(8'h64, 8'h40);
    rd(8'h24, 8'h1B);
    settle();
    rd(8'h14, 8'h1B);
    $display("gpio test done");
    @(posedge clk_sys);
    extEn <= 32'hFF000000;
    extLvl <= 32'hA5000000;
    settle();
    rd(8'h1C, 8'hA5);
    rd(8'h2C, 8'hFF);
    wr(8'h4C, 8'hF0);
    settle();
    rd(8'h1C, 8'hA0);
    chk(32'(pullupEn[31:24]), 32'hF0);
    wr(8'h40, 8'h00);
    rd(8'h40, 8'hFF);
    $display("input test done");
    @(posedge clk_sys);
    extEn <= 32'hFF000002;
    extLvl <= 32'hA5000002;
    periphDriveEn <= 33'h000000001;
    settle();
    chk(32'(periphIn[1]), 32'h0);
    wr(8'h00, 8'h04);
    wr(8'h10, 8'h00);
    settle();
    chk(32'(pinOeN[2:0]), 32'h2);
    chk(32'(periphIn[1]), 32'h1);
    @(posedge clk_sys);
    periphOut <= 33'h000000001;
    settle();
    chk(32'(pinOeN[0]), 32'h1);
    wr(8'h30, 8'hFF);
    settle();
    chk(32'({pinOeN[1:0], pinOut[0]}), 32'h5);
    @(posedge clk_sys);
    extEn <= 32'hFF000000;
    periphDriveEn <= 33'h000000003;
    periphOut <= 33'h000000003;
    settle();
    chk(32'(pinOeN[1]), 32'h0);
    @(posedge clk_sys);
    uartAMode0 <= 1'b1;
    settle();
    chk(32'(pinOeN[1]), 32'h1);
    $display("uart test done");
    @(posedge clk_sys);
    periphDriveEn <= 33'h0000001C7;
    periphOut <= 33'h000000147;
    wr(8'h44, 8'hFC);
    wr(8'h08, 8'h14);
    wr(8'h00, 8'h07);
    settle();
    chk(32'({pinOeN[7:5], pinOut[2]}), 32'h7);
    chk(32'({pinOeN[11], pinOut[10]}), 32'h3);
    chk(32'(pullupEn[7]), 32'h0);
    @(posedge clk_sys);
    periphDriveEn <= 33'h0000003C7;
    periphOut <= 33'h000000347;
    settle();
    chk(32'(pinOeN[11]), 32'h0);
    @(posedge clk_sys);
    uartBMode0 <= 1'b1;
    settle();
    chk(32'(pinOeN[11]), 32'h1);
    $display("priority test done");
    wr(8'h08, 8'h94);
    settle();
    chk(pullupEn, 32'h0);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h00);
    settle();
    chk(pinOeN, 32'hFFFFFFFF);
    rd(8'h70, 8'h00);
    $display("global test done");
    test_done();
  end
endmodule
`default_nettype wire
